/* src/xma_defines.vh */
// Notes on behaviour
// - Nonvolatile writes refused until keys 00,27,81,1F,77 land in key register upper byte.
// - Direct register reads and writes work at once after power-on, no unlock.
// - Nonvolatile reads are always allowed, whatever lock or protection.
// - Protection field 0xC blocks nonvolatile writes; shadow writes still accepted.
// - Protection field 0x3 blocks both nonvolatile and shadow writes.
// - Programmed protection can never be cleared; reads remain possible. Here reset reloads the level from LOCK_INIT.
// - Writing 0x80 to write control upper byte writes the low 24 data bits to the address.
// - Write-done flag, bit 0 of write control low byte, sets on completion.
// - Shadow write completes in one clock after the synchronised request.
// - Access to a locked location terminates, sets done flag and error warning.
// - An aborted nonvolatile write also sets the error bit in the error register.
// - Read address then 0x80 to read control fetches the location into read data.
// - Nonvolatile read takes up to 2 us; read-done flag bit 0 sets on completion.
// - Shadow read completes in one clock after the synchronised request.
// - Nonvolatile word: check code in 31:26, zeros in 25:24, value in 23:0.
// - Shadow locations use the same protocol at nonvolatile address plus 0x40.
// - Host may send the next command while the previous answer returns.
// - Shadow writes are blocked only by protection field 0x3 and need no unlock.
// - Shadow copies hold no check code; absent bits read as zero.
`ifndef XMA_DEFINES_VH
`define XMA_DEFINES_VH
`define XMA_OFF_WADDR     6'h02
`define XMA_OFF_WDATA_HI  6'h04
`define XMA_OFF_WDATA_LO  6'h06
`define XMA_OFF_WCTL      6'h08
`define XMA_OFF_RADDR     6'h0A
`define XMA_OFF_RCTL      6'h0C
`define XMA_OFF_RDATA_HI  6'h0E
`define XMA_OFF_RDATA_LO  6'h10
`define XMA_OFF_ERR       6'h24
`define XMA_OFF_WARN      6'h26
`define XMA_OFF_KEY       6'h3C
`define XMA_EXEC_BIT      15
`define XMA_BUSY_BIT      8
`define XMA_DONE_BIT      0
`define XMA_ERR_XEE_BIT   2
`define XMA_WARN_XEE_BIT  7
`define XMA_KEY0          8'h00
`define XMA_KEY1          8'h27
`define XMA_KEY2          8'h81
`define XMA_KEY3          8'h1F
`define XMA_KEY4          8'h77
`define XMA_LOCK_NV       4'hC
`define XMA_LOCK_ALL      4'h3
`define XMA_SHADOW_BASE   8'h40
`define XMA_SHADOW_MASK   32'h00FFFFFF
`define XMA_NV_ZERO_MASK  32'hFCFFFFFF
`define XMA_CLK_MHZ       250
`define XMA_NV_WRITE_US   24000
`define XMA_NV_READ_US    2
`define XMA_NV_WRITE_CYC  (`XMA_NV_WRITE_US * `XMA_CLK_MHZ)
`define XMA_NV_READ_CYC   (`XMA_NV_READ_US * `XMA_CLK_MHZ)
`endif

/* src/xma_ext_access.v */
`timescale 1ns/1ps
`include "xma_defines.vh"
// Extended memory access engine behind the direct serial register port.
// The register port is byte wide: i_wr writes i_wdata to byte i_addr; i_rd returns
// the 16-bit word at the even address at or below i_addr one cycle later on o_rdata.
module xma_ext_access #(
  parameter integer WR_CYCLES = `XMA_NV_WRITE_CYC,
  parameter integer RD_CYCLES = `XMA_NV_READ_CYC,
  parameter [3:0]   LOCK_INIT = 4'h0
) (
  input  wire        i_clk_sys,
  input  wire        i_resetn,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [5:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [15:0] o_rdata,
  output reg         o_rvalid,
  output reg         o_wr_busy,
  output reg         o_rd_busy,
  output reg         o_xee_err,
  output reg         o_xee_warn
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WNV  = 2'h1;
  localparam [1:0] ST_RNV  = 2'h2;

  reg  [1:0]  state_r;
  reg  [7:0]  waddr_r;
  reg  [31:0] wdata_r;
  reg  [7:0]  raddr_r;
  reg  [31:0] rdata_r;
  reg         wdone_r;
  reg         rdone_r;
  reg  [3:0]  lock_r;
  reg  [23:0] shadow_r [0:63];
  reg         wgo_r;
  reg         rgo_r;

  wire        unlocked;
  wire [31:0] nv_rdata;
  wire        nv_done;
  wire        nv_busy;
  wire        key_we = i_wr && i_addr == `XMA_OFF_KEY;
  wire        w_is_sh = waddr_r[7:6] == 2'b01;
  wire        r_is_sh = raddr_r[7:6] == 2'b01;
  wire        w_is_nv = waddr_r[7:6] == 2'b00;
  wire        r_is_nv = raddr_r[7:6] == 2'b00;
  wire        lock_nv = lock_r == `XMA_LOCK_NV || lock_r == `XMA_LOCK_ALL;
  wire        lock_sh = lock_r == `XMA_LOCK_ALL;
  // Shadow writes are blocked only at protection level 0x3 and need no unlock.
  wire        w_deny  = w_is_nv ? (lock_nv || !unlocked) :
                        w_is_sh ? lock_sh : 1'b1;
  wire        nv_wgo  = wgo_r && state_r == ST_IDLE && w_is_nv && !w_deny;
  wire        nv_rgo  = rgo_r && state_r == ST_IDLE && !wgo_r && r_is_nv;

  xma_unlock u_unlock (
    .i_clk_sys  (i_clk_sys),
    .i_resetn   (i_resetn),
    .i_key_we   (key_we),
    .i_key_byte (i_wdata),
    .o_unlocked (unlocked)
  );

  xma_nvm_store #(
    .DEPTH     (64),
    .WR_CYCLES (WR_CYCLES),
    .RD_CYCLES (RD_CYCLES)
  ) u_store (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_wr_go   (nv_wgo),
    .i_rd_go   (nv_rgo),
    .i_addr    (state_r == ST_IDLE && !wgo_r ? raddr_r[5:0] : waddr_r[5:0]),
    .i_wdata   (wdata_r),
    .o_rdata   (nv_rdata),
    .o_done    (nv_done),
    .o_busy    (nv_busy)
  );

  // Shadow array has no power-up defaults and no reset; reset of the serial port never clears it.
  always @(posedge i_clk_sys) begin
    if (wgo_r && state_r == ST_IDLE && w_is_sh && !w_deny)
      shadow_r[waddr_r[5:0]] <= wdata_r[23:0];
  end

  // Direct register writes need no preparation after reset.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      raddr_r <= 8'h00;
      wgo_r   <= 1'b0;
      rgo_r   <= 1'b0;
    end else begin
      if (state_r == ST_IDLE)
        wgo_r <= 1'b0;
      if (state_r == ST_IDLE && !wgo_r)
        rgo_r <= 1'b0;
      if (i_wr) begin
        case (i_addr)
          `XMA_OFF_WADDR + 6'h01:    waddr_r <= i_wdata;
          `XMA_OFF_WDATA_HI:         wdata_r[31:24] <= i_wdata;
          `XMA_OFF_WDATA_HI + 6'h01: wdata_r[23:16] <= i_wdata;
          `XMA_OFF_WDATA_LO:         wdata_r[15:8] <= i_wdata;
          `XMA_OFF_WDATA_LO + 6'h01: wdata_r[7:0] <= i_wdata;
          `XMA_OFF_WCTL:             if (i_wdata[7]) wgo_r <= 1'b1;
          `XMA_OFF_RADDR + 6'h01:    raddr_r <= i_wdata;
          `XMA_OFF_RCTL:             if (i_wdata[7]) rgo_r <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // A write launch wins over a read launch in the same cycle; the read waits.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r    <= ST_IDLE;
      rdata_r    <= 32'h00000000;
      wdone_r    <= 1'b0;
      rdone_r    <= 1'b0;
      o_xee_err  <= 1'b0;
      o_xee_warn <= 1'b0;
      o_wr_busy  <= 1'b0;
      o_rd_busy  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wgo_r) begin
            if (w_deny) begin
              wdone_r    <= 1'b1;
              o_wr_busy  <= 1'b0;
              o_xee_warn <= 1'b1;
              if (w_is_nv)
                o_xee_err <= 1'b1;
            end else if (w_is_sh) begin
              wdone_r   <= 1'b1;
              o_wr_busy <= 1'b0;
            end else begin
              state_r <= ST_WNV;
            end
          end else if (rgo_r) begin
            if (r_is_sh) begin
              rdata_r   <= {8'h00, shadow_r[raddr_r[5:0]]};
              rdone_r   <= 1'b1;
              o_rd_busy <= 1'b0;
            end else if (r_is_nv) begin
              state_r <= ST_RNV;
            end else begin
              rdone_r    <= 1'b1;
              o_rd_busy  <= 1'b0;
              o_xee_warn <= 1'b1;
            end
          end
        end
        ST_WNV: begin
          if (nv_done) begin
            wdone_r   <= 1'b1;
            o_wr_busy <= 1'b0;
            state_r   <= ST_IDLE;
          end
        end
        ST_RNV: begin
          if (nv_done) begin
            rdata_r   <= nv_rdata;
            rdone_r   <= 1'b1;
            o_rd_busy <= 1'b0;
            state_r   <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // A launch in the cycle a transfer completes must win over the completion.
      // Otherwise the queued request would report idle and done before it has run.
      if (i_wr && i_addr == `XMA_OFF_WCTL && i_wdata[7]) begin
        wdone_r   <= 1'b0;
        o_wr_busy <= 1'b1;
      end
      if (i_wr && i_addr == `XMA_OFF_RCTL && i_wdata[7]) begin
        rdone_r   <= 1'b0;
        o_rd_busy <= 1'b1;
      end
    end
  end

  // Protection level lives in the last nonvolatile word, low nibble. Once a level is
  // set no write path clears it, since nonvolatile writes are blocked from then on.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      lock_r <= LOCK_INIT;
    else if (state_r == ST_WNV && nv_done && waddr_r[5:0] == 6'h3F && !lock_nv)
      lock_r <= wdata_r[3:0];
  end

  // Read data: the word at the even address; unused addresses read zero.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        case ({i_addr[5:1], 1'b0})
          `XMA_OFF_WADDR:    o_rdata <= {8'h00, waddr_r};
          `XMA_OFF_WDATA_HI: o_rdata <= wdata_r[31:16];
          `XMA_OFF_WDATA_LO: o_rdata <= wdata_r[15:0];
          `XMA_OFF_WCTL:     o_rdata <= {7'h00, o_wr_busy, 7'h00, wdone_r};
          `XMA_OFF_RADDR:    o_rdata <= {8'h00, raddr_r};
          `XMA_OFF_RCTL:     o_rdata <= {7'h00, o_rd_busy, 7'h00, rdone_r};
          `XMA_OFF_RDATA_HI: o_rdata <= rdata_r[31:16];
          `XMA_OFF_RDATA_LO: o_rdata <= rdata_r[15:0];
          `XMA_OFF_ERR:      o_rdata <= {13'h0000, o_xee_err, 2'b00};
          `XMA_OFF_WARN:     o_rdata <= {8'h00, o_xee_warn, 7'h00};
          `XMA_OFF_KEY:      o_rdata <= {15'h0000, unlocked};
          default:           o_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // xma_ext_access

/* src/xma_nvm_store.v */
`timescale 1ns/1ps
`include "xma_defines.vh"
// Nonvolatile array model with timed write and read; words keep the check code layout.
module xma_nvm_store #(
  parameter integer DEPTH     = 64,
  parameter integer WR_CYCLES = `XMA_NV_WRITE_CYC,
  parameter integer RD_CYCLES = `XMA_NV_READ_CYC
) (
  input  wire        i_clk_sys,
  input  wire        i_resetn,
  input  wire        i_wr_go,
  input  wire        i_rd_go,
  input  wire [5:0]  i_addr,
  input  wire [31:0] i_wdata,
  output reg  [31:0] o_rdata,
  output reg         o_done,
  output reg         o_busy
);
  reg [31:0] mem_r [0:DEPTH-1];
  reg [31:0] cnt_r;
  reg        is_wr_r;
  reg [5:0]  addr_r;
  reg [31:0] data_r;

  function [5:0] chk;
    input [23:0] v;
    integer k;
    begin
      chk = 6'h00;
      for (k = 0; k < 24; k = k + 1)
        chk[k % 6] = chk[k % 6] ^ v[k];
    end
  endfunction

  // Array contents are nonvolatile and so are not cleared by reset.
  always @(posedge i_clk_sys) begin
    if (o_busy && is_wr_r && cnt_r == 32'h00000001)
      mem_r[addr_r] <= {chk(data_r[23:0]), 2'b00, data_r[23:0]};
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r   <= 32'h00000000;
      is_wr_r <= 1'b0;
      addr_r  <= 6'h00;
      data_r  <= 32'h00000000;
      o_rdata <= 32'h00000000;
      o_done  <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && (i_wr_go || i_rd_go)) begin
        o_busy  <= 1'b1;
        is_wr_r <= i_wr_go;
        addr_r  <= i_addr;
        data_r  <= i_wdata;
        cnt_r   <= i_wr_go ? WR_CYCLES : RD_CYCLES;
      end else if (o_busy) begin
        if (cnt_r == 32'h00000001) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          if (!is_wr_r)
            o_rdata <= mem_r[addr_r] & `XMA_NV_ZERO_MASK;
        end else begin
          cnt_r <= cnt_r - 32'h00000001;
        end
      end
    end
  end
endmodule // xma_nvm_store

/* src/xma_unlock.v */
`timescale 1ns/1ps
`include "xma_defines.vh"
// Tracks the five-step key sequence written to the key register upper byte.
module xma_unlock (
  input  wire       i_clk_sys,
  input  wire       i_resetn,
  input  wire       i_key_we,
  input  wire [7:0] i_key_byte,
  output reg        o_unlocked
);
  reg  [2:0] step_r;
  reg  [7:0] expect_c;

  always @* begin
    case (step_r)
      3'h0:    expect_c = `XMA_KEY0;
      3'h1:    expect_c = `XMA_KEY1;
      3'h2:    expect_c = `XMA_KEY2;
      3'h3:    expect_c = `XMA_KEY3;
      default: expect_c = `XMA_KEY4;
    endcase
  end

  // A wrong byte restarts the sequence; a stray 0x00 counts as a fresh first key.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      step_r     <= 3'h0;
      o_unlocked <= 1'b0;
    end else if (i_key_we && !o_unlocked) begin
      if (i_key_byte == expect_c) begin
        if (step_r == 3'h4) begin
          o_unlocked <= 1'b1;
          step_r     <= 3'h0;
        end else begin
          step_r <= step_r + 3'h1;
        end
      end else if (i_key_byte == `XMA_KEY0) begin
        step_r <= 3'h1;
      end else begin
        step_r <= 3'h0;
      end
    end
  end
endmodule // xma_unlock

/* test/extended_memory_access_unit_bench.sv */
`timescale 1ns/1ps
module extended_memory_access_unit_bench;
  logic        i_clk_sys = 1'b0;
  logic        i_resetn = 1'b0;
  logic        wr, rd, rvalid, wbusy, rbusy, xerr, xwarn, lk_err, lk_warn;
  logic [5:0]  addr;
  logic [7:0]  wdata;
  logic [15:0] rdata, d16;
  logic [31:0] v;
  logic [5:0]  offs[7] = '{6'h00, 6'h08, 6'h0C, 6'h12, 6'h2E, 6'h3C, 6'h3E};
  logic [7:0]  keys[5] = '{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};
  int          errors = 0;
  int          num_checks = 0;
  int          nv[int], sh[int];
  int          lockv = 0, unl = 0, m_err = 0, m_warn = 0;
  initial forever #2 i_clk_sys = ~i_clk_sys;
  xma_host host (.i_clk_sys(i_clk_sys), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
  xma_ext_access #(.WR_CYCLES(20), .RD_CYCLES(5)) uut (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_wr_busy(wbusy), .o_rd_busy(rbusy),
    .o_xee_err(xerr), .o_xee_warn(xwarn));
  // A second unit powers up fully protected and sees the same traffic.
  xma_ext_access #(.WR_CYCLES(20), .RD_CYCLES(5), .LOCK_INIT(4'h3)) uut_lock (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(), .o_rvalid(), .o_wr_busy(), .o_rd_busy(),
    .o_xee_err(lk_err), .o_xee_warn(lk_warn));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_done(input logic [5:0] off);
    logic [15:0] d;
    for (int n = 0; n < 100; n++) begin
      host.rd(off, d);
      if (d[0] === 1'b1) return;
    end
    errors++;
    $display("FAIL %0t done flag never set", $time);
    stop_test();
  endtask
  task automatic ext_wr(input int a, input logic [31:0] d);
    logic [15:0] s;
    int den;
    den = a > 8'h7F || lockv == 3 || (a < 8'h40 && (unl == 0 || lockv == 12));
    host.wr(6'h03, a[7:0]);
    for (int i = 0; i < 4; i++) host.wr(6'h04 + i[5:0], d[31 - 8 * i -: 8]);
    host.wr(6'h08, 8'h80);
    if (!den && a < 8'h40) begin
      host.rd(6'h08, s);
      cmp_word({16'h0000, s}, 32'h00000100);
    end
    wait_done(6'h08);
    cmp_flag(wbusy, 1'b0);
    if (den) begin
      m_warn = 1;
      m_err |= a < 8'h40;
    end else if (a < 8'h40) begin
      nv[a] = d & 32'h00FFFFFF;
      if (a == 8'h3F && (d[3:0] == 4'hC || d[3:0] == 4'h3)) lockv = d[3:0];
    end else begin
      sh[a - 8'h40] = d & 32'h00FFFFFF;
    end
    cmp_flag(xwarn, m_warn[0]);
    cmp_flag(xerr, m_err[0]);
  endtask
  task automatic ext_rd(input int a);
    logic [15:0] hi, lo;
    host.wr(6'h0B, a[7:0]);
    host.wr(6'h0C, 8'h80);
    if (a < 8'h40) begin
      host.rd(6'h0C, hi);
      cmp_word({16'h0000, hi}, 32'h00000100);
    end
    wait_done(6'h0C);
    cmp_flag(rbusy, 1'b0);
    host.rd(6'h0E, hi);
    host.rd(6'h10, lo);
    if (a < 8'h40) cmp_word({hi, lo} & 32'h03FFFFFF, nv[a]);
    else cmp_word({hi, lo}, sh[a - 8'h40]);
  endtask
  initial begin
    void'($urandom(32'hDEE2));
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    foreach (offs[i]) begin
      host.rd(offs[i], d16);
      cmp_word({16'h0000, d16}, 32'h00000000);
    end
    host.wr(6'h03, 8'h5A);
    host.rd(6'h02, d16);
    cmp_word({16'h0000, d16}, 32'h0000005A);
    $display("test direct access done");
    v = $urandom;
    ext_wr(8'h45, v);
    ext_rd(8'h45);
    cmp_flag(lk_warn, 1'b1);
    cmp_flag(lk_err, 1'b0);
    $display("test shadow access done");
    ext_wr(8'h90, $urandom);
    ext_wr(8'h05, $urandom);
    $display("test locked access done");
    host.wr(6'h3C, 8'h27);
    foreach (keys[i]) begin
      host.rd(6'h3C, d16);
      cmp_word({16'h0000, d16}, 32'h00000000);
      host.wr(6'h3C, keys[i]);
    end
    host.rd(6'h3C, d16);
    cmp_word({16'h0000, d16}, 32'h00000001);
    unl = 1;
    ext_wr(8'h1F, $urandom);
    ext_rd(8'h1F);
    ext_wr(8'h00, $urandom);
    ext_rd(8'h00);
    $display("test nonvolatile access done");
    v = $urandom;
    ext_wr(8'h3F, {v[31:4], 4'hC});
    ext_wr(8'h3F, 32'h00000003);
    ext_rd(8'h3F);
    ext_wr(8'h46, $urandom);
    ext_rd(8'h46);
    ext_wr(8'h10, $urandom);
    $display("test protection done");
    stop_test();
  end
endmodule // extended_memory_access_unit_bench

/* test/xma_host.sv */
`timescale 1ns/1ps
// Serial host seen at the register port; released lines flip so stale values never pass.
module xma_host (
  input  wire logic        i_clk_sys,
  output logic             o_wr,
  output logic             o_rd,
  output logic [5:0]       o_addr,
  output logic [7:0]       o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    o_addr <= ~a;
    // Valid stands for one cycle only, so the word is taken mid-cycle while it stands.
    @(negedge i_clk_sys);
    d = i_rvalid ? i_rdata : 16'hXXXX;
  endtask
endmodule // xma_host

/* test/xma_props.sv */
`timescale 1ns/1ps
module xma_props #(
  parameter integer WR_CYCLES = 20,
  parameter integer RD_CYCLES = 5
) (
  input wire        i_clk_sys,
  input wire        i_resetn,
  input wire        i_wr,
  input wire        i_rd,
  input wire [5:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire [15:0] o_rdata,
  input wire        o_rvalid,
  input wire        o_wr_busy,
  input wire        o_rd_busy,
  input wire        o_xee_err,
  input wire        o_xee_warn
);
  int wcnt_r;
  int rcnt_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_wexec;
    i_wr && i_addr == 6'h08 && i_wdata[7];
  endsequence
  sequence s_rd_void;
    i_rd && (i_addr == 6'h12 || i_addr == 6'h2E);
  endsequence
  // Busy spans are counted so that a hung engine fails even with long real timings.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wcnt_r <= 0;
      rcnt_r <= 0;
    end else begin
      wcnt_r <= o_wr_busy ? wcnt_r + 1 : 0;
      rcnt_r <= o_rd_busy ? rcnt_r + 1 : 0;
    end
  end
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read strobe not answered next cycle");
  a_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
    else $error("read valid without a read");
  a_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
    else $error("read data moved without a read");
  a_void_zero: assert property (s_rd_void |=> o_rdata == 16'h0000)
    else $error("unused register not zero");
  a_wbusy_cause: assert property ($rose(o_wr_busy) |-> $past(i_wr && i_addr == 6'h08
    && i_wdata[7]))
    else $error("write busy without execute");
  a_wr_bound: assert property (wcnt_r <= WR_CYCLES + 8)
    else $error("write busy too long");
  a_rd_bound: assert property (rcnt_r <= RD_CYCLES + 8)
    else $error("read busy too long");
  a_err_warn: assert property ($rose(o_xee_err) |-> o_xee_warn)
    else $error("error without warning");
  a_err_sticky: assert property (o_xee_err |=> o_xee_err)
    else $error("error flag dropped");
  a_warn_sticky: assert property (o_xee_warn |=> o_xee_warn)
    else $error("warning flag dropped");
  a_warn_cause: assert property ($rose(o_xee_warn) |-> $past(i_wr && i_wdata[7], 1)
    || $past(i_wr && i_wdata[7], 2) || $past(o_wr_busy || o_rd_busy))
    else $error("warning without an access");
  c_wexec: cover property (s_wexec);
endmodule // xma_props
bind xma_ext_access xma_props #(.WR_CYCLES(WR_CYCLES), .RD_CYCLES(RD_CYCLES)) u_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_wr_busy(o_wr_busy), .o_rd_busy(o_rd_busy), .o_xee_err(o_xee_err),
  .o_xee_warn(o_xee_warn));
